// ---- lut_bank_map.svh ----
`ifndef LUT_BANK_MAP_SVH
`define LUT_BANK_MAP_SVH

// ****************************************************************
// Table selects and byte offsets
// ****************************************************************
`define MOD_TBL     8'h04
`define BIAS_TBL    8'h06
`define PRESET_TBL  8'h08
`define CONV_TBL    8'h09
`define LUT_BASE    8'h80
`define LUT_LAST    8'hA7
`define CEIL_BASE   8'hF0
`define OFS_BASE    8'hF8
`define ENTRY_RESET 8'h00

// ****************************************************************
// Temperature indexing
// ****************************************************************
`define TEMP_FLOOR  10'sh028
`define TEMP_STEP   1
`define OFS_SHIFT   3
`define MOD_SHIFT   2

`endif

// ---- lut_bank_pkg.sv ----
package lut_bank_pkg;

    // Laser control loop selection
    typedef enum logic [1:0] {
        LOOP_OPEN = 2'h0,
        LOOP_APC  = 2'h1,
        LOOP_DUAL = 2'h2
    } loop_mode_e;

    // Recall sequencer, one-hot
    typedef enum logic [1:0] {
        ST_IDLE   = 2'h1,
        ST_RECALL = 2'h2
    } recall_state_e;

    // Decoded byte access from the two-wire slave
    typedef struct packed {
        logic       req;
        logic       write;
        logic       aux;
        logic [7:0] table_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } access_s;

    // Password level and table permissions
    typedef struct packed {
        logic level_two_password;
        logic level_one_password;
        logic laser_tables_rw_permit;
        logic laser_tables_read_permit;
        logic preset_tables_rw_permit;
        logic preset_tables_read_permit;
    } permit_s;

endpackage

// ---- lut_table.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lut_bank_map.svh"

module lut_table #(
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic          clk,
    input  wire logic          rst,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [7:0]    rd_data,
    input  wire logic [AW-1:0] rc_addr,
    output logic      [7:0]    rc_data
);

    logic [7:0] mem [DEPTH];

    // Byte storage, cleared at reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= `ENTRY_RESET;
            end
        end else if (wr_en && (int'(wr_addr) < DEPTH)) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Host and recall read ports, out of range reads zero
    assign rd_data = (int'(rd_addr) < DEPTH) ? mem[rd_addr] : `ENTRY_RESET;
    assign rc_data = (int'(rc_addr) < DEPTH) ? mem[rc_addr] : `ENTRY_RESET;

endmodule // lut_table
`default_nettype wire

// ---- laser_temperature_lut_bank.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "lut_bank_map.svh"

module laser_temperature_lut_bank
    import lut_bank_pkg::*;
#(
    parameter int LUT_DEPTH = 40,
    parameter int AUX_DEPTH = 256
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire access_s    acc,
    input  wire permit_s    perm,
    input  wire loop_mode_e loop_mode,
    input  wire logic       conv_done,
    input  wire logic [7:0] temperature,
    input  wire logic       manual_bias,
    input  wire logic [9:0] manual_bias_value,
    output logic      [7:0] rd_data,
    output logic            rd_valid,
    output logic            access_denied,
    output logic      [5:0] temperature_index,
    output logic      [9:0] bias_current_setting,
    output logic      [10:0] modulation_current_setting,
    output logic      [7:0] incrementing_byte
);

    // ************************************************************
    // Permission and address decode
    // ************************************************************
    logic laser_rd_ok, laser_wr_ok, preset_rd_ok, preset_wr_ok;
    logic is_laser, is_preset, in_lut, in_small, rd_ok, wr_ok;
    logic [1:0] lut_hit;
    logic [5:0] small_hit;
    logic       aux_hit;

    // Level two alone, or level one with a permit
    assign laser_rd_ok  = perm.level_two_password | (perm.level_one_password
        & (perm.laser_tables_rw_permit | perm.laser_tables_read_permit));
    assign laser_wr_ok  = perm.level_two_password
        | (perm.level_one_password & perm.laser_tables_rw_permit);
    assign preset_rd_ok = perm.level_two_password | (perm.level_one_password
        & (perm.preset_tables_rw_permit | perm.preset_tables_read_permit));
    assign preset_wr_ok = perm.level_two_password
        | (perm.level_one_password & perm.preset_tables_rw_permit);

    assign is_laser  = !acc.aux && (acc.table_sel == `MOD_TBL
                                 || acc.table_sel == `BIAS_TBL);
    assign is_preset = !acc.aux && (acc.table_sel == `PRESET_TBL
                                 || acc.table_sel == `CONV_TBL);
    assign in_lut    = acc.addr >= `LUT_BASE && acc.addr <= `LUT_LAST;
    assign in_small  = acc.addr >= `CEIL_BASE;
    assign rd_ok     = (is_laser & laser_rd_ok) | (is_preset & preset_rd_ok)
                     | acc.aux;
    assign wr_ok     = (is_laser & laser_wr_ok) | (is_preset & preset_wr_ok)
                     | acc.aux;

    // Region hits; small tables: mod ceil, mod ofs, bias ceil, bias ofs,
    // presets, converter offsets
    assign lut_hit[0]   = is_laser && acc.table_sel == `MOD_TBL && in_lut;
    assign lut_hit[1]   = is_laser && acc.table_sel == `BIAS_TBL && in_lut;
    assign small_hit[0] = acc.table_sel == `MOD_TBL && in_small
                       && acc.addr < `OFS_BASE && !acc.aux;
    assign small_hit[1] = acc.table_sel == `MOD_TBL
                       && acc.addr >= `OFS_BASE && !acc.aux;
    assign small_hit[2] = acc.table_sel == `BIAS_TBL && in_small
                       && acc.addr < `OFS_BASE && !acc.aux;
    assign small_hit[3] = acc.table_sel == `BIAS_TBL
                       && acc.addr >= `OFS_BASE && !acc.aux;
    assign small_hit[4] = acc.table_sel == `PRESET_TBL
                       && acc.addr >= `OFS_BASE && !acc.aux;
    assign small_hit[5] = acc.table_sel == `CONV_TBL
                       && acc.addr >= `OFS_BASE && !acc.aux;
    assign aux_hit      = acc.aux;

    // ************************************************************
    // Storage
    // ************************************************************
    logic [7:0] lut_rd [2];
    logic [7:0] lut_rc [2];
    logic [7:0] sm_rd  [6];
    logic [7:0] sm_rc  [6];
    logic [7:0] aux_rd;
    logic [1:0] lut_we;
    logic [5:0] sm_we;
    logic       aux_we;
    logic [2:0] ofs_index;

    assign ofs_index = 3'(temperature_index >> `OFS_SHIFT);

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_lut
            assign lut_we[g] = acc.req && acc.write && wr_ok
                            && lut_hit[g];
            lut_table #(.DEPTH(LUT_DEPTH), .AW(6)) u_lut (
                .clk     (clk),
                .rst     (rst),
                .wr_en   (lut_we[g]),
                .wr_addr (acc.addr[5:0]),
                .wr_data (acc.wdata),
                .rd_addr (acc.addr[5:0]),
                .rd_data (lut_rd[g]),
                .rc_addr (temperature_index),
                .rc_data (lut_rc[g])
            );
        end
        for (g = 0; g < 6; g++) begin : g_small
            assign sm_we[g] = acc.req && acc.write && wr_ok
                           && small_hit[g];
            lut_table #(.DEPTH(8), .AW(3)) u_small (
                .clk     (clk),
                .rst     (rst),
                .wr_en   (sm_we[g]),
                .wr_addr (acc.addr[2:0]),
                .wr_data (acc.wdata),
                .rd_addr (acc.addr[2:0]),
                .rd_data (sm_rd[g]),
                .rc_addr (ofs_index),
                .rc_data (sm_rc[g])
            );
        end
    endgenerate

    assign aux_we = acc.req && acc.write && aux_hit;
    lut_table #(.DEPTH(AUX_DEPTH), .AW(8)) u_aux (
        .clk     (clk),
        .rst     (rst),
        .wr_en   (aux_we),
        .wr_addr (acc.addr),
        .wr_data (acc.wdata),
        .rd_addr (acc.addr),
        .rd_data (aux_rd),
        .rc_addr (acc.addr),
        .rc_data ()
    );

    // ************************************************************
    // Host read answer
    // ************************************************************
    logic [7:0] next_rd_data;

    // Merge region data; refused or empty reads give zero
    always_comb begin
        next_rd_data = `ENTRY_RESET;
        if (rd_ok) begin
            for (int i = 0; i < 2; i++) begin
                if (lut_hit[i]) next_rd_data = next_rd_data | lut_rd[i];
            end
            for (int i = 0; i < 6; i++) begin
                if (small_hit[i]) next_rd_data = next_rd_data | sm_rd[i];
            end
            if (aux_hit) next_rd_data = aux_rd;
        end
    end

    // Registered read data, valid and refusal pulses
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data       <= `ENTRY_RESET;
            rd_valid      <= 1'b0;
            access_denied <= 1'b0;
        end else begin
            rd_valid      <= acc.req && !acc.write;
            access_denied <= acc.req && (acc.write ? !wr_ok : !rd_ok);
            if (acc.req && !acc.write) begin
                rd_data <= next_rd_data;
            end
        end
    end

    // ************************************************************
    // Temperature recall
    // ************************************************************
    recall_state_e state;
    logic signed [9:0] temp_shift;
    logic [5:0]        next_temperature_index;

    // Offset from the floor, halved for the step, clamped to the table
    always_comb begin
        temp_shift = ($signed({{2{temperature[7]}}, temperature})
                   + `TEMP_FLOOR) >>> `TEMP_STEP;
        if (temp_shift < 0) begin
            next_temperature_index = 6'h00;
        end else if (temp_shift > 10'(LUT_DEPTH - 1)) begin
            next_temperature_index = 6'(LUT_DEPTH - 1);
        end else begin
            next_temperature_index = temp_shift[5:0];
        end
    end

    // Sequencer: latch index on conversion, recall next cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state             <= ST_IDLE;
            temperature_index <= 6'h00;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (conv_done) begin
                        temperature_index <= next_temperature_index;
                        state             <= ST_RECALL;
                    end
                end
                ST_RECALL: state <= ST_IDLE;
                default:   state <= ST_IDLE;
            endcase
        end
    end

    // Active bias: manual value, or recalled entry scaled by loop mode
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            bias_current_setting <= 10'h000;
        end else if (manual_bias) begin
            bias_current_setting <= manual_bias_value;
        end else if (state == ST_RECALL) begin
            if (loop_mode == LOOP_OPEN) begin
                bias_current_setting <= {2'h0, lut_rc[1]};
            end else begin
                bias_current_setting <= {lut_rc[1], 2'h0};
            end
        end
    end

    // Active modulation and incrementing byte, both taken at recall
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            modulation_current_setting <= 11'h000;
            incrementing_byte          <= 8'h00;
        end else if (state == ST_RECALL) begin
            modulation_current_setting <= {3'h0, lut_rc[0]}
                + ({3'h0, sm_rc[1]} << `MOD_SHIFT);
            incrementing_byte[7:4] <= sm_rc[4][7:4];
            incrementing_byte[3:0] <= sm_rc[4][3:0];
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_INDEX_LATCH: assert property (@(posedge clk) disable iff (rst)
        state == ST_IDLE && conv_done
        |=> temperature_index == $past(next_temperature_index))
        else $error("index not taken from temperature");

    AST_BIAS_HOLD: assert property (@(posedge clk) disable iff (rst)
        state == ST_IDLE && !manual_bias |=> $stable(bias_current_setting))
        else $error("bias changed between conversions");

    AST_MANUAL: assert property (@(posedge clk) disable iff (rst)
        manual_bias |=> bias_current_setting == $past(manual_bias_value))
        else $error("manual bias not applied");

    AST_BIAS_SCALE: assert property (@(posedge clk) disable iff (rst)
        state == ST_RECALL && !manual_bias
        |=> bias_current_setting == (($past(loop_mode) == LOOP_OPEN)
            ? {2'h0, $past(lut_rc[1])} : {$past(lut_rc[1]), 2'h0}))
        else $error("bias scaling wrong for loop mode");

    AST_CONV_TO_BIAS: assert property (@(posedge clk) disable iff (rst)
        state == ST_IDLE && conv_done && !manual_bias
        ##1 !manual_bias |=> bias_current_setting[1:0] == 2'h0
            || loop_mode == LOOP_OPEN)
        else $error("closed loop bias low bits not clear");

    AST_MOD_SUM: assert property (@(posedge clk) disable iff (rst)
        state == ST_RECALL |=> modulation_current_setting
            == 11'($past(lut_rc[0])) + 11'($past(sm_rc[1])) * 11'h004)
        else $error("modulation sum wrong");

    AST_INC_NIBBLES: assert property (@(posedge clk) disable iff (rst)
        state == ST_RECALL |=> incrementing_byte == $past(sm_rc[4]))
        else $error("incrementing byte not updated");

    AST_LASER_READ_DENY: assert property (@(posedge clk) disable iff (rst)
        acc.req && !acc.write && is_laser && !laser_rd_ok
        |=> rd_valid && access_denied && rd_data == 8'h00)
        else $error("laser table read leaked");

    AST_PRESET_READ_DENY: assert property (@(posedge clk) disable iff (rst)
        acc.req && !acc.write && is_preset && !preset_rd_ok
        |=> access_denied && rd_data == 8'h00)
        else $error("preset table read leaked");

    AST_AUX_READ: assert property (@(posedge clk) disable iff (rst)
        acc.req && !acc.write && acc.aux
        |=> rd_valid && !access_denied && rd_data == $past(aux_rd))
        else $error("auxiliary read wrong");

    AST_WRITE_IGNORED: assert property (@(posedge clk) disable iff (rst)
        acc.req && acc.write && !wr_ok |-> lut_we == 2'h0 && sm_we == 6'h00
        ##1 access_denied)
        else $error("refused write reached storage");

endmodule // laser_temperature_lut_bank
`default_nettype wire

// ---- two_wire_host.sv ----
`timescale 1ns/10ps
`default_nettype none

module two_wire_host
    import lut_bank_pkg::*;
(
    input  wire logic       clk,
    output var  access_s    acc,
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid,
    input  wire logic       access_denied
);
    // ****************************************************************
    // Byte transfers
    // ****************************************************************
    initial acc = '0;

    // One byte; request held for the taking edge, answer one cycle on
    task automatic xfer(input logic w, input logic x, input logic [7:0] t,
                        input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] rd, output logic den,
                        output logic vld);
        access_s idle;
        @(posedge clk);
        acc <= '{req: 1'h1, write: w, aux: x, table_sel: t, addr: a,
                 wdata: d};
        @(posedge clk);
        idle = ~acc;
        idle.req = 1'h0;
        acc <= idle; // Released bus shows inverted value
        #1;
        rd = rd_data;
        den = access_denied;
        vld = rd_valid;
    endtask

    // Same value in every bias entry, compensation off
    task automatic fill_bias(input logic [7:0] v);
        logic [7:0] rd;
        logic       den;
        logic       vld;
        for (int i = 0; i < 40; i++) begin
            xfer(1'h1, 1'h0, 8'h06, 8'(8'h80 + i), v, rd, den, vld);
        end
    endtask
endmodule // two_wire_host

`default_nettype wire

// ---- laser_temperature_lut_bank_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module laser_temperature_lut_bank_tb_top
    import lut_bank_pkg::*;
;
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    typedef struct packed {
        logic [5:0] p;
        logic       w;
        logic       x;
        logic [7:0] t;
        logic [7:0] a;
        logic [7:0] d;
        logic [7:0] e;
        logic       den;
    } row_s;

    logic        clk = 1'h0;
    logic        rst = 1'h1;
    access_s     acc;
    permit_s     perm = '0;
    loop_mode_e  loop_mode = LOOP_OPEN;
    logic        conv_done = 1'h0;
    logic [7:0]  temperature = 8'h00;
    logic        manual_bias = 1'h0;
    logic [9:0]  manual_bias_value = 10'h000;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        access_denied;
    logic [5:0]  temperature_index;
    logic [9:0]  bias_current_setting;
    logic [10:0] modulation_current_setting;
    logic [7:0]  incrementing_byte;
    int          failures = 0;
    int          n_tests = 0;
    row_s        rows [0:27];

    always #10 clk = ~clk;

    laser_temperature_lut_bank laser_temperature_lut_bank_i (
        .clk(clk), .rst(rst), .acc(acc), .perm(perm),
        .loop_mode(loop_mode), .conv_done(conv_done),
        .temperature(temperature), .manual_bias(manual_bias),
        .manual_bias_value(manual_bias_value), .rd_data(rd_data),
        .rd_valid(rd_valid), .access_denied(access_denied),
        .temperature_index(temperature_index),
        .bias_current_setting(bias_current_setting),
        .modulation_current_setting(modulation_current_setting),
        .incrementing_byte(incrementing_byte));

    two_wire_host two_wire_host_i (
        .clk(clk), .acc(acc), .rd_data(rd_data), .rd_valid(rd_valid),
        .access_denied(access_denied));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [10:0] got, input logic [10:0] exp,
                       input string what);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // Conversion pulse, then settle past the setting update
    task automatic recall(input logic [7:0] t);
        @(posedge clk);
        conv_done <= 1'h1;
        temperature <= t;
        @(posedge clk);
        conv_done <= 1'h0;
        @(posedge clk);
        #1;
    endtask

    task automatic put(input logic [7:0] t, input logic [7:0] a,
                       input logic [7:0] d);
        logic [7:0] rd;
        logic       den;
        logic       vld;
        two_wire_host_i.xfer(1'h1, 1'h0, t, a, d, rd, den, vld);
    endtask

    task automatic summarize();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Watchdog
    initial begin
        #100000;
        failures++;
        summarize();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] rd;
        logic       den;
        logic       vld;
        rows = '{
            '{6'h20, 1'h0, 1'h0, 8'h06, 8'hA0, 8'h00, 8'h00, 1'h0},
            '{6'h20, 1'h1, 1'h0, 8'h06, 8'h80, 8'h5A, 8'h00, 1'h0},
            '{6'h14, 1'h0, 1'h0, 8'h06, 8'h80, 8'h00, 8'h5A, 1'h0},
            '{6'h10, 1'h0, 1'h0, 8'h06, 8'h80, 8'h00, 8'h00, 1'h1},
            '{6'h18, 1'h1, 1'h0, 8'h06, 8'h81, 8'hA5, 8'h00, 1'h0},
            '{6'h14, 1'h1, 1'h0, 8'h06, 8'h81, 8'h3C, 8'h00, 1'h1},
            '{6'h18, 1'h0, 1'h0, 8'h06, 8'h81, 8'h00, 8'hA5, 1'h0},
            '{6'h12, 1'h1, 1'h0, 8'h08, 8'hF8, 8'hC3, 8'h00, 1'h0},
            '{6'h11, 1'h0, 1'h0, 8'h08, 8'hF8, 8'h00, 8'hC3, 1'h0},
            '{6'h18, 1'h0, 1'h0, 8'h08, 8'hF8, 8'h00, 8'h00, 1'h1},
            '{6'h18, 1'h1, 1'h0, 8'h09, 8'hFF, 8'h77, 8'h00, 1'h1},
            '{6'h12, 1'h0, 1'h0, 8'h09, 8'hFF, 8'h00, 8'h00, 1'h0},
            '{6'h00, 1'h1, 1'h1, 8'h06, 8'h00, 8'h11, 8'h00, 1'h0},
            '{6'h00, 1'h1, 1'h1, 8'h00, 8'hFF, 8'hEE, 8'h00, 1'h0},
            '{6'h00, 1'h0, 1'h1, 8'h00, 8'h00, 8'h00, 8'h11, 1'h0},
            '{6'h00, 1'h0, 1'h1, 8'h04, 8'hFF, 8'h00, 8'hEE, 1'h0},
            '{6'h20, 1'h1, 1'h0, 8'h06, 8'hA8, 8'h99, 8'h00, 1'h0},
            '{6'h20, 1'h0, 1'h0, 8'h06, 8'hA8, 8'h00, 8'h00, 1'h0},
            '{6'h20, 1'h1, 1'h0, 8'h04, 8'hF8, 8'h12, 8'h00, 1'h0},
            '{6'h20, 1'h0, 1'h0, 8'h04, 8'hF8, 8'h00, 8'h12, 1'h0},
            '{6'h20, 1'h1, 1'h0, 8'h06, 8'hF0, 8'h3E, 8'h00, 1'h0},
            '{6'h20, 1'h1, 1'h0, 8'h06, 8'hF8, 8'h4D, 8'h00, 1'h0},
            '{6'h20, 1'h0, 1'h0, 8'h06, 8'hF0, 8'h00, 8'h3E, 1'h0},
            '{6'h20, 1'h0, 1'h0, 8'h06, 8'hF8, 8'h00, 8'h4D, 1'h0},
            '{6'h20, 1'h1, 1'h0, 8'h09, 8'hF8, 8'h5E, 8'h00, 1'h0},
            '{6'h20, 1'h0, 1'h0, 8'h09, 8'hF8, 8'h00, 8'h5E, 1'h0},
            '{6'h20, 1'h1, 1'h0, 8'h04, 8'hF1, 8'h2D, 8'h00, 1'h0},
            '{6'h20, 1'h0, 1'h0, 8'h04, 8'hF1, 8'h00, 8'h2D, 1'h0}};
        // Reset held for 20 cycles, outputs cleared
        repeat (20) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        chk(11'(bias_current_setting), 11'h000, "bias reset");
        chk(modulation_current_setting, 11'h000, "mod reset");
        chk(11'(incrementing_byte), 11'h000, "increment_byte_presets reset");
        chk(11'(temperature_index), 11'h000, "idx reset");
        chk(11'({rd_valid, access_denied, rd_data}), 11'h000, "bus reset");
        // Table of ordinary accesses
        foreach (rows[i]) begin
            @(posedge clk);
            perm <= rows[i].p;
            two_wire_host_i.xfer(rows[i].w, rows[i].x, rows[i].t, rows[i].a,
                                 rows[i].d, rd, den, vld);
            chk(11'(den), 11'(rows[i].den), "denied");
            if (!rows[i].w) begin
                chk(11'(rd), 11'(rows[i].e), "rd_data");
                if (!rows[i].den)
                    chk(11'(vld), 11'h001, "rd_valid");
            end
        end
        // Flat bias profile, index boundaries
        @(posedge clk);
        perm <= 6'h20;
        two_wire_host_i.fill_bias(8'h40);
        recall(8'hD8);
        chk(11'(temperature_index), 11'h000, "idx -40");
        chk(11'(bias_current_setting), 11'h040, "bias flat");
        recall(8'h64);
        chk(11'(temperature_index), 11'h027, "idx clamp");
        chk(11'(bias_current_setting), 11'h040, "bias flat end");
        // Entry 32 in closed loop, offsets and presets
        put(8'h06, 8'hA0, 8'hB7);
        put(8'h04, 8'hA0, 8'hF0);
        put(8'h04, 8'hFC, 8'h81);
        put(8'h08, 8'hFC, 8'h6C);
        @(posedge clk);
        loop_mode <= LOOP_APC;
        recall(8'h19);
        chk(11'(temperature_index), 11'h020, "idx 25");
        chk(11'(bias_current_setting), 11'h2DC, "bias apc");
        chk(modulation_current_setting, 11'h2F4, "mod");
        chk(11'(incrementing_byte), 11'h06C, "increment_byte_presets");
        // Setting holds after a table change
        put(8'h06, 8'hA0, 8'h11);
        repeat (3) @(posedge clk);
        #1;
        chk(11'(bias_current_setting), 11'h2DC, "bias hold");
        @(posedge clk);
        loop_mode <= LOOP_DUAL;
        recall(8'h18);
        chk(11'(bias_current_setting), 11'h044, "bias dual");
        @(posedge clk);
        loop_mode <= LOOP_OPEN;
        recall(8'h1A);
        chk(11'(temperature_index), 11'h021, "idx 26");
        recall(8'h18);
        chk(11'(bias_current_setting), 11'h011, "bias open");
        // Manual mode overrides recall
        @(posedge clk);
        manual_bias <= 1'h1;
        manual_bias_value <= 10'h2A5;
        repeat (3) @(posedge clk);
        recall(8'h1A);
        chk(11'(bias_current_setting), 11'h2A5, "manual");
        // Mid-run reset clears settings and tables
        @(posedge clk);
        manual_bias <= 1'h0;
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        #1;
        chk(11'(bias_current_setting), 11'h000, "bias rst2");
        chk(modulation_current_setting, 11'h000, "mod rst2");
        chk(11'(incrementing_byte), 11'h000, "increment_byte_presets rst2");
        chk(11'(temperature_index), 11'h000, "idx rst2");
        two_wire_host_i.xfer(1'h0, 1'h0, 8'h06, 8'hA0, 8'h00, rd, den, vld);
        chk(11'(rd), 11'h000, "table rst2");
        two_wire_host_i.xfer(1'h0, 1'h0, 8'h08, 8'hFC, 8'h00, rd, den, vld);
        chk(11'(rd), 11'h000, "preset rst2");
        summarize();
    end
endmodule // laser_temperature_lut_bank_tb_top

`default_nettype wire
